//--- hdl/ocl_pkg.sv
package ocl_pkg;

    // ==========================================================
    // geometry
    localparam int FUSE_BANKS      = 10;
    localparam int FUSE_BITS       = 26;
    localparam int BANK_IDX_W      = 4;
    localparam logic [3:0] BANK_LAST = 4'h9;

    // ==========================================================
    // bus target address
    localparam logic [3:0] ADDR_BASE   = 4'h8;
    localparam logic       ADDR_HI_BIT = 1'h1;

    // ==========================================================
    // clocks
    localparam int CORE_CLK_HZ     = 50_000_000;
    localparam int FAST_OSC_HZ     = 16_000_000;
    localparam int SLOW_CLK_HZ     = 32_000;
    localparam int SWITCH_CLK_HZ   = 2_000_000;
    // divide ratios of the 16 MHz oscillator
    localparam int SLOW_DIV        = FAST_OSC_HZ / SLOW_CLK_HZ;
    localparam int SWITCH_DIV      = FAST_OSC_HZ / SWITCH_CLK_HZ;
    localparam logic [9:0] SLOW_HALF   = 10'(SLOW_DIV / 2 - 1);
    localparam logic [2:0] SWITCH_HALF = 3'(SWITCH_DIV / 2 - 1);
    // trim step in tenths of a percent, nominal trim code
    localparam int TRIM_STEP_PERMILLE  = 30;
    localparam logic [3:0] TRIM_FACTORY = 4'h8;

    // ==========================================================
    // power button
    localparam int HOLD_OFF_MS     = 4000;
    localparam int HOLD_OFF_CYC    = HOLD_OFF_MS * (SLOW_CLK_HZ / 1000);

    // ==========================================================
    // loader
    typedef enum logic [1:0] {
        OCL_SRC_NONE,
        OCL_SRC_FUSE,
        OCL_SRC_SHADOW,
        OCL_SRC_FACTORY
    } ocl_src_e;

    typedef enum {
        OCL_ST_CLEAR,
        OCL_ST_WAIT,
        OCL_ST_DECIDE,
        OCL_ST_LOAD,
        OCL_ST_READY,
        OCL_ST_ON
    } ocl_state_e;

    function automatic logic [BANK_IDX_W-1:0] ocl_bank_next(
        input logic [BANK_IDX_W-1:0] idx
    );
        ocl_bank_next = idx + 4'h1;
    endfunction : ocl_bank_next

endpackage : ocl_pkg

//--- hdl/ocl_ecc_fix.sv
`timescale 1ns/1ps
`default_nettype none
// single-error correction over one bank word: syndrome names the flipped bit
module ocl_ecc_fix
    import ocl_pkg::*;
(
    // data
    input  wire logic [FUSE_BITS-1:0] raw_word,
    input  wire logic [4:0]           syndrome,
    input  wire logic                 ecc_on,
    output logic      [FUSE_BITS-1:0] fixed_word
);
    always_comb begin
        fixed_word = raw_word;
        // syndrome 0 = clean; 1..26 point at a data bit, rest uncorrectable
        if (ecc_on && syndrome != 5'h00 && syndrome <= 5'(FUSE_BITS)) begin
            fixed_word[5'(syndrome - 5'h01)] = ~raw_word[5'(syndrome - 5'h01)];
        end
    end
endmodule : ocl_ecc_fix
`default_nettype wire

//--- hdl/ocl_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
// divides the fast oscillator tick into 32 kHz and 2 MHz ticks
module ocl_clk_div
    import ocl_pkg::*;
(
    // clock and reset
    input  wire logic core_clk,
    input  wire logic nrst,
    // fast tick in
    input  wire logic fast_tick,
    // divided ticks
    output logic      slow_tick,
    output logic      sw_tick
);
    logic [9:0] slow_cnt_ff;
    logic [2:0] sw_cnt_ff;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            slow_cnt_ff <= 10'h000;
            slow_tick   <= 1'b0;
        end else begin
            slow_tick <= 1'b0;
            if (fast_tick) begin
                if (slow_cnt_ff == 10'(SLOW_DIV - 1)) begin
                    slow_cnt_ff <= 10'h000;
                    slow_tick   <= 1'b1;
                end else begin
                    slow_cnt_ff <= slow_cnt_ff + 10'h001;
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            sw_cnt_ff <= 3'h0;
            sw_tick   <= 1'b0;
        end else begin
            sw_tick <= 1'b0;
            if (fast_tick) begin
                if (sw_cnt_ff == 3'(SWITCH_DIV - 1)) begin
                    sw_cnt_ff <= 3'h0;
                    sw_tick   <= 1'b1;
                end else begin
                    sw_cnt_ff <= sw_cnt_ff + 3'h1;
                end
            end
        end
    end
endmodule : ocl_clk_div
`default_nettype wire

//--- hdl/ocl_loader.sv
`timescale 1ns/1ps
`default_nettype none
module ocl_loader
    import ocl_pkg::*;
#(
    parameter int HOLD_CYC = HOLD_OFF_CYC,
    parameter logic [FUSE_BANKS*FUSE_BITS-1:0] FACTORY_CFG = '0
) (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  nrst,
    // pins and supply state (asynchronous)
    input  wire logic                  vin_valid,
    input  wire logic                  fuse_supply_select_pin,
    input  wire logic                  power_button_pin,
    input  wire logic                  input_below_uv_threshold,
    input  wire logic                  all_regs_sleep,
    input  wire logic                  all_regs_pfm,
    // oscillator ticks (same domain)
    input  wire logic                  fast_osc_tick,
    input  wire logic                  untrimmed_slow_tick,
    // control bits
    input  wire logic                  keep_shadow_set,
    input  wire logic                  keep_shadow_clr,
    input  wire logic [2:0]            fuse_load_request_bits,
    input  wire logic                  fuse_all_required,
    input  wire logic                  ecc_select,
    input  wire logic                  power_button_input_mode,
    input  wire logic [3:0]            trim_code,
    // host shadow write port
    input  wire logic                  shadow_wr,
    input  wire logic [BANK_IDX_W-1:0] shadow_idx,
    input  wire logic [FUSE_BITS-1:0]  shadow_wdata,
    output logic      [FUSE_BITS-1:0]  shadow_rdata,
    output logic      [2:0]            bus_target_address_field,
    // fuse array read port
    output logic      [BANK_IDX_W-1:0] fuse_idx,
    input  wire logic [FUSE_BITS-1:0]  fuse_rdata,
    input  wire logic [4:0]            fuse_syndrome,
    // status
    output logic      [6:0]            bus_target_address,
    output logic      [1:0]            load_source,
    output logic                       load_done,
    output logic                       seq_start,
    output logic                       powered_on,
    output logic                       use_untrimmed_clk,
    output logic                       debounce_tick,
    output logic                       irq_debounce_tick,
    output logic                       switch_clk_tick,
    output logic                       keep_shadow_on_powerup,
    output logic                       fuse_load_enable,
    output logic      [3:0]            osc_trim
);
    // ==========================================================
    // synchronisers
    logic [1:0] vin_s_ff, sel_s_ff, btn_s_ff, uv_s_ff, slp_s_ff, pfm_s_ff;
    logic       vin_q, sel_q, btn_q, uv_q, slp_q, pfm_q;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            vin_s_ff <= 2'h0;
            sel_s_ff <= 2'h0;
            btn_s_ff <= 2'h0;
            uv_s_ff  <= 2'h0;
            slp_s_ff <= 2'h0;
            pfm_s_ff <= 2'h0;
        end else begin
            vin_s_ff <= {vin_s_ff[0], vin_valid};
            sel_s_ff <= {sel_s_ff[0], fuse_supply_select_pin};
            btn_s_ff <= {btn_s_ff[0], power_button_pin};
            uv_s_ff  <= {uv_s_ff[0], input_below_uv_threshold};
            slp_s_ff <= {slp_s_ff[0], all_regs_sleep};
            pfm_s_ff <= {pfm_s_ff[0], all_regs_pfm};
        end
    end
    assign vin_q = vin_s_ff[1];
    assign sel_q = sel_s_ff[1];
    assign btn_q = btn_s_ff[1];
    assign uv_q  = uv_s_ff[1];
    assign slp_q = slp_s_ff[1];
    assign pfm_q = pfm_s_ff[1];

    // ==========================================================
    // clocks
    logic slow_tick, sw_tick;
    ocl_clk_div u_div (
        .core_clk  (core_clk),
        .nrst      (nrst),
        .fast_tick (fast_osc_tick),
        .slow_tick (slow_tick),
        .sw_tick   (sw_tick)
    );

    logic nxt_untrim;
    assign nxt_untrim = uv_q || slp_q || pfm_q;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            use_untrimmed_clk <= 1'b0;
            debounce_tick     <= 1'b0;
            irq_debounce_tick <= 1'b0;
            switch_clk_tick   <= 1'b0;
            osc_trim          <= TRIM_FACTORY;
        end else begin
            use_untrimmed_clk <= nxt_untrim;
            debounce_tick     <= nxt_untrim ? untrimmed_slow_tick : slow_tick;
            irq_debounce_tick <= untrimmed_slow_tick;
            switch_clk_tick   <= sw_tick;
            osc_trim          <= trim_code;
        end
    end

    // ==========================================================
    // control bits
    // fuse enable
    logic nxt_fuse_en;
    assign nxt_fuse_en = fuse_all_required ? (&fuse_load_request_bits)
                                           : (^fuse_load_request_bits);

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            fuse_load_enable <= 1'b0;
        end else begin
            fuse_load_enable <= nxt_fuse_en;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            keep_shadow_on_powerup <= 1'b0;
        end else if (keep_shadow_set) begin
            keep_shadow_on_powerup <= 1'b1;
        end else if (keep_shadow_clr) begin
            keep_shadow_on_powerup <= 1'b0;
        end
    end

    // ==========================================================
    // power button turn-on and turn-off events
    logic        btn_prev_ff;
    logic [17:0] hold_cnt_ff;
    logic        turn_on, turn_off;

    assign turn_on  = power_button_input_mode ? (btn_prev_ff && !btn_q) : btn_q;
    assign turn_off = power_button_input_mode ? (hold_cnt_ff == 18'(HOLD_CYC))
                                              : !btn_q;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            btn_prev_ff <= 1'b0;
            hold_cnt_ff <= 18'h00000;
        end else begin
            btn_prev_ff <= btn_q;
            if (btn_q) begin
                hold_cnt_ff <= 18'h00000;
            end else if (slow_tick && hold_cnt_ff != 18'(HOLD_CYC)) begin
                hold_cnt_ff <= hold_cnt_ff + 18'h00001;
            end
        end
    end

    // ==========================================================
    // loader state machine
    ocl_state_e            state_ff;
    ocl_src_e              src_ff;
    logic [BANK_IDX_W-1:0] idx_ff;
    logic [FUSE_BITS-1:0]  shadow_ff [FUSE_BANKS];
    logic [FUSE_BITS-1:0]  fixed_word;

    ocl_ecc_fix u_ecc (
        .raw_word   (fuse_rdata),
        .syndrome   (fuse_syndrome),
        .ecc_on     (ecc_select),
        .fixed_word (fixed_word)
    );

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            state_ff <= OCL_ST_CLEAR;
            src_ff   <= OCL_SRC_NONE;
            idx_ff   <= '0;
        end else if (!vin_q) begin
            state_ff <= OCL_ST_CLEAR;
            idx_ff   <= '0;
        end else begin
            case (state_ff)
                OCL_ST_CLEAR: begin
                    idx_ff <= ocl_bank_next(idx_ff);
                    if (idx_ff == BANK_LAST) begin
                        idx_ff   <= '0;
                        state_ff <= OCL_ST_WAIT;
                    end
                end
                OCL_ST_WAIT: begin
                    if (turn_on) begin
                        state_ff <= OCL_ST_DECIDE;
                    end
                end
                OCL_ST_DECIDE: begin
                    // single sample of select and control bits
                    idx_ff <= '0;
                    if (sel_q) begin
                        src_ff   <= OCL_SRC_FACTORY;
                        state_ff <= OCL_ST_LOAD;
                    end else if (keep_shadow_on_powerup) begin
                        src_ff   <= OCL_SRC_SHADOW;
                        state_ff <= OCL_ST_READY;
                    end else if (fuse_load_enable) begin
                        src_ff   <= OCL_SRC_FUSE;
                        state_ff <= OCL_ST_LOAD;
                    end else begin
                        src_ff   <= OCL_SRC_NONE;
                        state_ff <= OCL_ST_WAIT;
                    end
                end
                OCL_ST_LOAD: begin
                    idx_ff <= ocl_bank_next(idx_ff);
                    if (idx_ff == BANK_LAST) begin
                        idx_ff   <= '0;
                        state_ff <= OCL_ST_READY;
                    end
                end
                OCL_ST_READY: begin
                    state_ff <= OCL_ST_ON;
                end
                OCL_ST_ON: begin
                    if (turn_off) begin
                        state_ff <= OCL_ST_WAIT;
                    end
                end
                default: begin
                    state_ff <= OCL_ST_CLEAR;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            for (int i = 0; i < FUSE_BANKS; i++) begin
                shadow_ff[i] <= '0;
            end
        end else if (vin_q && state_ff == OCL_ST_CLEAR) begin
            shadow_ff[idx_ff] <= '0;
        end else if (vin_q && state_ff == OCL_ST_LOAD) begin
            shadow_ff[idx_ff] <= (src_ff == OCL_SRC_FUSE) ? fixed_word
                               : FACTORY_CFG[idx_ff*FUSE_BITS +: FUSE_BITS];
        end else if (vin_q && shadow_wr && shadow_idx <= BANK_LAST) begin
            shadow_ff[shadow_idx] <= shadow_wdata;
        end
    end

    // ==========================================================
    // outputs
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            shadow_rdata             <= '0;
            bus_target_address_field <= 3'h0;
            bus_target_address       <= {3'h0, ADDR_BASE};
            fuse_idx                 <= '0;
            load_source              <= OCL_SRC_NONE;
            load_done                <= 1'b0;
            seq_start                <= 1'b0;
            powered_on               <= 1'b0;
        end else begin
            shadow_rdata <= (shadow_idx <= BANK_LAST) ? shadow_ff[shadow_idx] : '0;
            bus_target_address_field <= shadow_ff[0][2:0];
            // upper address bit fixed at one
            bus_target_address <= {3'h0, ADDR_HI_BIT, shadow_ff[0][2:0]};
            fuse_idx    <= (state_ff == OCL_ST_LOAD) ? ocl_bank_next(idx_ff) : '0;
            load_source <= src_ff;
            load_done   <= (state_ff == OCL_ST_READY) || (state_ff == OCL_ST_ON);
            // sequencer starts from READY, after the bank load or straight from DECIDE when the shadow is kept
            seq_start   <= (state_ff == OCL_ST_READY);
            powered_on  <= (state_ff == OCL_ST_ON);
        end
    end

    // ==========================================================
    // checks
    addr_range_a: assert property (@(posedge core_clk) disable iff (!nrst)
        bus_target_address[6:3] == 4'h1)
        else $error("target address outside 0x08..0x0F");
    clear_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_ff == OCL_ST_CLEAR && vin_q) |=> shadow_ff[$past(idx_ff)] == '0)
        else $error("shadow bank not cleared");
    factory_sel_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_ff == OCL_ST_DECIDE && vin_q && sel_q) |=> src_ff == OCL_SRC_FACTORY)
        else $error("factory source not chosen");
    fuse_sel_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_ff == OCL_ST_DECIDE && vin_q && !sel_q && !keep_shadow_on_powerup
         && fuse_load_enable) |=> src_ff == OCL_SRC_FUSE)
        else $error("fuse source not chosen");
    fuse_xor_a: assert property (@(posedge core_clk) disable iff (!nrst)
        nrst && !fuse_all_required |=> fuse_load_enable ==
        ^$past(fuse_load_request_bits))
        else $error("fuse enable not xor of requests");
    no_start_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_ff == OCL_ST_DECIDE && vin_q && !sel_q && !keep_shadow_on_powerup
         && !fuse_load_enable) |=> state_ff == OCL_ST_WAIT ##1 !seq_start)
        else $error("start-up without source");
    shadow_keep_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_ff == OCL_ST_DECIDE && vin_q && !sel_q && keep_shadow_on_powerup)
        |=> ##1 seq_start)
        else $error("shadow power-up missing");
    load_len_a: assert property (@(posedge core_clk) disable iff (!nrst)
        (state_ff == OCL_ST_DECIDE && vin_q && sel_q) |=> ##10 state_ff == OCL_ST_READY)
        else $error("load did not finish in ten cycles");

    fuse_cov_c: cover property (@(posedge core_clk) disable iff (!nrst)
        src_ff == OCL_SRC_FUSE && seq_start);
    shadow_cov_c: cover property (@(posedge core_clk) disable iff (!nrst)
        src_ff == OCL_SRC_SHADOW && seq_start);
    fact_cov_c: cover property (@(posedge core_clk) disable iff (!nrst)
        src_ff == OCL_SRC_FACTORY && seq_start);
endmodule : ocl_loader
`default_nettype wire

//--- testbench/ocl_fuse_model.sv
`timescale 1ns/1ps
`default_nettype none
module ocl_fuse_model
    import ocl_pkg::*;
(
    // array address and error injection
    input  wire logic [BANK_IDX_W-1:0] fuse_idx,
    input  wire logic [4:0]            err_syn,
    // array answer
    output logic      [FUSE_BITS-1:0]  fuse_rdata,
    output logic      [4:0]            fuse_syndrome
);
    // ==========================================
    // fuse banks
    // ten banks
    // past the last bank a changing pattern, never a stale bank
    assign fuse_rdata    = (fuse_idx <= BANK_LAST) ? {22'h2D1C3, fuse_idx + 4'h3}
                                                   : {22'h12E3C, ~fuse_idx};
    assign fuse_syndrome = err_syn;
endmodule : ocl_fuse_model
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb
    import ocl_pkg::*;
;
    // ==========================================
    // signals
    logic core_clk, nrst, vin_valid, fuse_supply_select_pin, power_button_pin;
    logic input_below_uv_threshold, all_regs_sleep, all_regs_pfm, fast_osc_tick;
    logic keep_shadow_set, keep_shadow_clr, fuse_all_required, ecc_select;
    logic power_button_input_mode, shadow_wr, load_done, seq_start, powered_on;
    logic use_untrimmed_clk, debounce_tick, irq_debounce_tick, switch_clk_tick;
    logic keep_shadow_on_powerup, fuse_load_enable, untrimmed_slow_tick;
    logic [2:0] fuse_load_request_bits, bus_target_address_field;
    logic [3:0] trim_code, shadow_idx, fuse_idx, osc_trim;
    logic [4:0] fuse_syndrome, err_syn;
    logic [6:0] bus_target_address;
    logic [1:0] load_source;
    logic [FUSE_BITS-1:0] shadow_wdata, shadow_rdata, fuse_rdata;
    int err_count, n_tests;
    int tcnt = 0;

    ocl_loader #(.HOLD_CYC(4), .FACTORY_CFG({FUSE_BANKS{26'h1234567}})) dut_u (.core_clk, .nrst,
        .vin_valid, .fuse_supply_select_pin, .power_button_pin, .input_below_uv_threshold,
        .all_regs_sleep, .all_regs_pfm, .fast_osc_tick, .untrimmed_slow_tick, .keep_shadow_set,
        .keep_shadow_clr, .fuse_load_request_bits,
        .fuse_all_required, .ecc_select, .power_button_input_mode, .trim_code, .shadow_wr,
        .shadow_idx, .shadow_wdata, .shadow_rdata, .bus_target_address_field, .fuse_idx,
        .fuse_rdata, .fuse_syndrome, .bus_target_address, .load_source, .load_done,
        .seq_start, .powered_on, .use_untrimmed_clk, .debounce_tick, .irq_debounce_tick,
        .switch_clk_tick, .keep_shadow_on_powerup, .fuse_load_enable, .osc_trim);
    ocl_fuse_model fuse_u (.fuse_idx, .err_syn, .fuse_rdata, .fuse_syndrome);

    // ==========================================
    // clock and oscillator ticks
    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    // 50 MHz core gives a fast tick every third cycle, near enough to 16 MHz
    always @(posedge core_clk) begin
        tcnt <= (tcnt % 48 == 47) ? 0 : tcnt + 1;
        fast_osc_tick <= (tcnt % 3 == 0);
        untrimmed_slow_tick <= (tcnt == 5);
    end

    // ==========================================
    // helpers
    function automatic logic [FUSE_BITS-1:0] fw(input int k);
        fw = {22'h2D1C3, 4'(k + 3)};
    endfunction : fw

    task automatic start(input logic sel, input logic [2:0] r, input logic a, input logic e);
        @(posedge core_clk);
        nrst <= 1'b0;
        vin_valid <= 1'b0;
        power_button_pin <= 1'b0;
        power_button_input_mode <= 1'b0;
        fuse_supply_select_pin <= sel;
        fuse_load_request_bits <= r;
        fuse_all_required <= a;
        ecc_select <= e;
        repeat (9) @(posedge core_clk);
        #1;
        `CHK("rst_addr", 7'h08, bus_target_address)
        `CHK("rst_keep", 1'b0, keep_shadow_on_powerup)
        `CHK("rst_trim", 4'h8, osc_trim)
        // release on the tenth edge so reset is seen low for ten cycles
        @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        vin_valid <= 1'b1;
        repeat (20) @(posedge core_clk);
        #1;
    endtask : start

    // drives the button to lvl; watches a fixed window for the start pulse
    task automatic turn_on(input logic lvl, output logic seen);
        seen = 1'b0;
        @(posedge core_clk);
        power_button_pin <= lvl;
        repeat (60) begin
            @(posedge core_clk);
            #1;
            if (seq_start === 1'b1) seen = 1'b1;
        end
    endtask : turn_on

    task automatic rd(input logic [3:0] i, output logic [FUSE_BITS-1:0] d);
        @(posedge core_clk);
        shadow_idx <= i;
        repeat (2) @(posedge core_clk);
        #1;
        d = shadow_rdata;
    endtask : rd

    task automatic wr(input logic [3:0] i, input logic [FUSE_BITS-1:0] d);
        @(posedge core_clk);
        shadow_wr <= 1'b1;
        shadow_idx <= i;
        shadow_wdata <= d;
        @(posedge core_clk);
        shadow_wr <= 1'b0;
    endtask : wr

    // ==========================================
    // scenarios
    task automatic t_fuse(input logic [2:0] r, input logic a, input logic en);
        logic                 s;
        logic [FUSE_BITS-1:0] d;
        start(1'b0, r, a, 1'b0);
        `CHK("fuse_en", en, fuse_load_enable)
        turn_on(1'b1, s);
        `CHK("started", en, s)
        `CHK("done", en, load_done)
        `CHK("source", en ? 2'h1 : 2'h0, load_source)
        `CHK("on", en, powered_on)
        rd(4'h3, d);
        `CHK("bank3", en ? fw(3) : 26'h0, d)
        `CHK("addr", en ? 7'h0B : 7'h08, bus_target_address)
        @(posedge core_clk);
        power_button_pin <= 1'b0;
        repeat (8) @(posedge core_clk);
        #1;
        `CHK("off", 1'b0, powered_on)
    endtask : t_fuse

    task automatic t_other;
        logic                 s;
        logic [FUSE_BITS-1:0] d;
        // factory load in edge mode; keep bit set to show the pin overrides it
        start(1'b1, 3'b111, 1'b0, 1'b0);
        @(posedge core_clk);
        power_button_input_mode <= 1'b1;
        power_button_pin <= 1'b1;
        keep_shadow_set <= 1'b1;
        @(posedge core_clk);
        keep_shadow_set <= 1'b0;
        repeat (20) @(posedge core_clk);
        #1;
        `CHK("edge_rise", 1'b0, powered_on)
        turn_on(1'b0, s);
        `CHK("edge_start", 1'b1, s)
        `CHK("fact_src", 2'h3, load_source)
        rd(4'h3, d);
        `CHK("fact_bank", 26'h1234567, d)
        `CHK("fact_addr", 7'h0F, bus_target_address)
        // hold-off is four slow periods of 1500 cycles each
        repeat (2900) @(posedge core_clk);
        #1;
        `CHK("hold_on", 1'b1, powered_on)
        repeat (3300) @(posedge core_clk);
        #1;
        `CHK("hold_off", 1'b0, powered_on)
        start(1'b0, 3'b100, 1'b0, 1'b1);
        @(posedge core_clk);
        err_syn <= 5'h01;
        turn_on(1'b1, s);
        rd(4'h3, d);
        `CHK("ecc_bank", fw(3) ^ 26'h1, d)
        `CHK("ecc_addr", 7'h0A, bus_target_address)
        start(1'b0, 3'b111, 1'b0, 1'b0);
        @(posedge core_clk);
        err_syn <= 5'h00;
        keep_shadow_set <= 1'b1;
        @(posedge core_clk);
        keep_shadow_set <= 1'b0;
        wr(4'h0, 26'h5);
        wr(4'h9, 26'h3FFFFFF);
        wr(4'hA, 26'h1);
        `CHK("keep", 1'b1, keep_shadow_on_powerup)
        turn_on(1'b1, s);
        `CHK("keep_start", 1'b1, s)
        `CHK("keep_src", 2'h2, load_source)
        rd(4'h9, d);
        `CHK("keep_bank9", 26'h3FFFFFF, d)
        `CHK("keep_field", 3'h5, bus_target_address_field)
        `CHK("keep_addr", 7'h0D, bus_target_address)
        rd(4'hA, d);
        `CHK("oob_bank", 26'h0, d)
        @(posedge core_clk);
        keep_shadow_clr <= 1'b1;
        @(posedge core_clk);
        keep_shadow_clr <= 1'b0;
        @(posedge core_clk);
        #1;
        `CHK("keep_clr", 1'b0, keep_shadow_on_powerup)
    endtask : t_other

    task automatic t_clocks;
        int n, nd, ni;
        n = 0;
        nd = 0;
        ni = 0;
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            {input_below_uv_threshold, all_regs_sleep, all_regs_pfm} <= 3'(4'h8 >> (3 - i));
            trim_code <= 4'(i + 3);
            repeat (6) @(posedge core_clk);
            #1;
            `CHK("untrimmed", i < 3, use_untrimmed_clk)
            `CHK("trim", 4'(i + 3), osc_trim)
        end
        // one slow period: 500 fast ticks, three core cycles apart
        repeat (1500) begin
            @(posedge core_clk);
            #1;
            if (switch_clk_tick === 1'b1) n++;
            if (debounce_tick === 1'b1) nd++;
            if (irq_debounce_tick === 1'b1) ni++;
        end
        // switching tick every 24 cycles, untrimmed tick every 48
        `CHK("sw_ticks", 1'b1, n >= 62 && n <= 63)
        `CHK("db_ticks", 1, nd)
        `CHK("irq_ticks", 1'b1, ni >= 31 && ni <= 32)
    endtask : t_clocks

    // ==========================================
    // verdict
    task automatic end_of_test;
        $display("comparisons %0d errors %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_of_test

    initial begin
        #400_000;
        err_count++;
        end_of_test();
    end

    initial begin
        {nrst, vin_valid, fuse_supply_select_pin, power_button_pin} = 4'h0;
        {input_below_uv_threshold, all_regs_sleep, all_regs_pfm, keep_shadow_set} = 4'h0;
        {keep_shadow_clr, fuse_all_required, ecc_select, power_button_input_mode} = 4'h0;
        {shadow_wr, fuse_load_request_bits, trim_code, shadow_idx, err_syn} = 17'h0;
        shadow_wdata = '0;
        t_fuse(3'b011, 1'b0, 1'b0);
        t_fuse(3'b111, 1'b0, 1'b1);
        t_fuse(3'b100, 1'b0, 1'b1);
        t_fuse(3'b011, 1'b1, 1'b0);
        t_fuse(3'b111, 1'b1, 1'b1);
        t_other();
        t_clocks();
        end_of_test();
    end
endmodule : tb
`default_nettype wire
